/* File: pkg/flash_seq_cfg.svh */
// Offsets, bit positions, reset values and timing of the flash sequencer.
// Assumes byte-wide registers on a small plain register port.
`ifndef FLASH_SEQ_CFG_SVH
`define FLASH_SEQ_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define FSC_OFF_CTRL 3'h0
`define FSC_OFF_UNLOCK 3'h1
`define FSC_OFF_LATCH 3'h2
`define FSC_OFF_PTR_L 3'h3
`define FSC_OFF_PTR_H 3'h4
`define FSC_OFF_PTR_U 3'h5
`define FSC_OFF_STAT 3'h6

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FSC_B_PGM 7
`define FSC_B_CFG 6
`define FSC_B_ERASE 4
`define FSC_B_ABORT 3
`define FSC_B_WRITE_ENABLE_BIT 2
`define FSC_B_GO 1
`define FSC_B_DONE 0
`define FSC_B_BUSY 1

// ----------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------
`define FSC_KEY1 8'h55
`define FSC_KEY2 8'hAA
`define FSC_HOLD_RST 8'hFF
`define FSC_BYTE_ZERO 8'h00
`define FSC_PTR_RST 22'h000000
`define FSC_HOLD_N 8

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define FSC_PROG_TIME_NS 2000000
`define FSC_CLK_PERIOD_NS 10
`define FSC_PROG_CYCLES (`FSC_PROG_TIME_NS / `FSC_CLK_PERIOD_NS)

`endif

/* File: pkg/fsc_pkg.sv */
// Types shared by the flash sequencer and its bench.
// Assumes the constants header is compiled alongside.
package fsc_pkg;

  // --------------------------------------------------------------------
  // State machines
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ERASE = 2'b01,
    ST_PROG = 2'b10
  } op_state_t;

  typedef enum logic [1:0] {
    UL_NONE = 2'b00,
    UL_KEY1 = 2'b01,
    UL_ARMED = 2'b10
  } unlock_state_t;

  // --------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic program_space_select;
    logic config_space_select;
    logic erase_select;
    logic write_abort_flag;
    logic write_enable_bit;
    logic write_start;
  } ctrl_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic rd_en;
    logic erase;
    logic prog;
    logic pump_en;
    logic [20:0] addr;
  } flash_cmd_t;

endpackage

/* File: design/self_program_flash_controller.sv */
// Self-programming sequencer for on-chip flash: table reads and writes,
// row erase and block programming. Assumes a flash array with a one-cycle
// read latency and a core that obeys the stall output.
//
// Implementation choices: the plain strobed port and the address map.
`include "flash_seq_cfg.svh"

// Overview of operation
// - Each table read fetches one byte at the pointer into the latch.
// - One byte per table read; pointer update is left to software.
// - Pointer bit 0 selects low or high byte of the flash word.
// - Erase always clears a whole 64-byte row, never a single word.
// - Erase uses pointer bits 21..6 as row; bits 5..0 ignored.
// - Start needs 55h then AAh to the unlock port before go.
// - Core is stalled while an erase or program runs.
// - Erase stall lasts about 2 ms from the programming timer.
// - Programming works only on 8-byte blocks.
// - Eight holding bytes; table writes load them only.
// - Holding bytes return to FFh on reset and after each finished write; an abort keeps them.
// - Holding byte FFh leaves its flash byte unchanged.
// - Partly loaded holding bytes still program; rest stay unchanged.
// - On-chip timer sets duration; charge pump enabled meanwhile.
// - Pointer bits 2..0 pick holding byte; bits 21..3 pick block.
// - Go bit settable only by software, cleared by hardware at end.
// - Write done flag set at end, held until software clears.
// - Abort request or bad start sets abort flag; an abort request keeps space selects, a bad start loads them from the write.
module self_program_flash_controller #(
  parameter int unsigned PROG_CYCLES = `FSC_PROG_CYCLES
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire fsc_pkg::reg_req_t REG_REQ,
  output logic [7:0] REG_RDATA,
  input wire logic TBL_RD_OP,
  input wire logic TBL_WR_OP,
  input wire logic ABORT_REQ,
  input wire logic [15:0] FLASH_RDATA,
  output fsc_pkg::flash_cmd_t FLASH_CMD,
  output logic [63:0] FLASH_PROG_DATA,
  output logic [7:0] FLASH_BYTE_EN,
  output logic CORE_STALL,
  output logic WRITE_DONE_FLAG
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  localparam int CNT_W = $clog2(PROG_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PROG_CYCLES - 1);

  fsc_pkg::op_state_t state_r, state_nxt;
  fsc_pkg::unlock_state_t ul_r, ul_nxt;
  fsc_pkg::ctrl_t ctrl_r, ctrl_nxt;
  fsc_pkg::flash_cmd_t cmd_r, cmd_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [21:0] ptr_r, ptr_nxt;
  logic [7:0] latch_r, latch_nxt;
  logic [7:0][7:0] hold_r;
  logic [7:0] ben_r, ben_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic hi1_r, hi2_r, rd_pend_r;
  logic stall_r, done_r, done_nxt;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
    hit = a == off;
  endfunction

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  wire logic [7:0] wd = REG_REQ.wdata;
  wire logic idle = state_r == fsc_pkg::ST_IDLE;
  wire logic wr_ctrl = REG_REQ.wr && hit(REG_REQ.addr, `FSC_OFF_CTRL);
  wire logic wr_unl = REG_REQ.wr && hit(REG_REQ.addr, `FSC_OFF_UNLOCK);
  wire logic wr_lat = REG_REQ.wr && hit(REG_REQ.addr, `FSC_OFF_LATCH);
  wire logic wr_stat = REG_REQ.wr && hit(REG_REQ.addr, `FSC_OFF_STAT);
  wire logic ctrl_wr_ok = wr_ctrl && idle;
  wire logic go_req = ctrl_wr_ok && wd[`FSC_B_GO];
  // Settings carried by the same write count, so a read-modify-write works
  wire logic go_ok = go_req && ul_r == fsc_pkg::UL_ARMED
    && wd[`FSC_B_WRITE_ENABLE_BIT] && wd[`FSC_B_PGM] && !wd[`FSC_B_CFG];
  wire logic go_bad = go_req && !go_ok;
  wire logic finish = !idle && cnt_r == CNT_LAST && !ABORT_REQ;
  wire logic abort = !idle && ABORT_REQ;

  // --------------------------------------------------------------------
  // Unlock sequence
  // --------------------------------------------------------------------
  // Any other write between the keys or before go disarms the start
  assign ul_nxt = !REG_REQ.wr ? ul_r :
    (wr_unl && wd == `FSC_KEY1) ? fsc_pkg::UL_KEY1 :
    (wr_unl && wd == `FSC_KEY2 && ul_r == fsc_pkg::UL_KEY1) ?
      fsc_pkg::UL_ARMED : fsc_pkg::UL_NONE;

  // --------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------
  wire logic pgm_nxt = ctrl_wr_ok ? wd[`FSC_B_PGM]
    : ctrl_r.program_space_select;
  wire logic cfg_nxt = ctrl_wr_ok ? wd[`FSC_B_CFG]
    : ctrl_r.config_space_select;
  wire logic write_enable_bit_nxt = ctrl_wr_ok ? wd[`FSC_B_WRITE_ENABLE_BIT]
    : ctrl_r.write_enable_bit;
  wire logic erase_nxt = ctrl_wr_ok ? wd[`FSC_B_ERASE] :
    (finish && state_r == fsc_pkg::ST_ERASE) ? 1'b0 : ctrl_r.erase_select;
  // Hardware set wins over a software clear in the same cycle
  wire logic abort_nxt = go_bad || abort ||
    (ctrl_wr_ok ? wd[`FSC_B_ABORT] : ctrl_r.write_abort_flag);
  wire logic go_nxt = go_ok ||
    (ctrl_r.write_start && !(finish || abort));
  assign ctrl_nxt = {pgm_nxt, cfg_nxt, erase_nxt, abort_nxt, write_enable_bit_nxt,
    go_nxt};
  assign done_nxt = finish ||
    (done_r && !(wr_stat && wd[`FSC_B_DONE]));

  // --------------------------------------------------------------------
  // Long write sequencer
  // --------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      fsc_pkg::ST_IDLE: begin
        if (go_ok) begin
          state_nxt = wd[`FSC_B_ERASE] ? fsc_pkg::ST_ERASE
            : fsc_pkg::ST_PROG;
        end
      end
      fsc_pkg::ST_ERASE, fsc_pkg::ST_PROG: begin
        if (finish || abort) begin
          state_nxt = fsc_pkg::ST_IDLE;
        end
      end
      default: state_nxt = fsc_pkg::ST_IDLE;
    endcase
  end

  // Timer length scales down for simulation
  assign cnt_nxt = idle ? '0 : CNT_W'(cnt_r + 1'b1);

  // --------------------------------------------------------------------
  // Pointer, latch and read path
  // --------------------------------------------------------------------
  assign ptr_nxt = !idle ? ptr_r :
    (REG_REQ.wr && hit(REG_REQ.addr, `FSC_OFF_PTR_L)) ?
      {ptr_r[21:8], wd} :
    (REG_REQ.wr && hit(REG_REQ.addr, `FSC_OFF_PTR_H)) ?
      {ptr_r[21:16], wd, ptr_r[7:0]} :
    (REG_REQ.wr && hit(REG_REQ.addr, `FSC_OFF_PTR_U)) ?
      {wd[5:0], ptr_r[15:0]} : ptr_r;
  // Flash data land one cycle after the strobe
  assign latch_nxt = rd_pend_r ?
    (hi2_r ? FLASH_RDATA[15:8] : FLASH_RDATA[7:0]) :
    wr_lat ? wd : latch_r;

  // --------------------------------------------------------------------
  // Flash command
  // --------------------------------------------------------------------
  wire logic [20:0] row_addr = {ptr_r[21:6], 5'h00};
  wire logic [20:0] blk_addr = {ptr_r[21:3], 2'h0};
  assign cmd_nxt.rd_en = TBL_RD_OP && idle;
  assign cmd_nxt.erase = state_nxt == fsc_pkg::ST_ERASE;
  assign cmd_nxt.prog = state_nxt == fsc_pkg::ST_PROG;
  assign cmd_nxt.pump_en = state_nxt != fsc_pkg::ST_IDLE;
  assign cmd_nxt.addr = go_ok ?
    (wd[`FSC_B_ERASE] ? row_addr : blk_addr) :
    (!idle) ? cmd_r.addr : TBL_RD_OP ? ptr_r[21:1] : cmd_r.addr;

  // --------------------------------------------------------------------
  // Holding bytes
  // --------------------------------------------------------------------
  for (genvar i = 0; i < `FSC_HOLD_N; i++) begin : g_hold
    wire logic sel = TBL_WR_OP && idle && ptr_r[2:0] == 3'(i);
    // Bytes left at FFh are masked out of the array write
    assign ben_nxt[i] = go_ok ? (hold_r[i] != `FSC_HOLD_RST)
      : (finish || abort) ? 1'b0 : ben_r[i];
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        hold_r[i] <= `FSC_HOLD_RST;
      end else if (finish) begin
        hold_r[i] <= `FSC_HOLD_RST;
      end else if (sel) begin
        hold_r[i] <= latch_r;
      end
    end
  end

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  wire logic [7:0] ctrl_byte = {ctrl_r.program_space_select,
    ctrl_r.config_space_select, 1'b0, ctrl_r.erase_select,
    ctrl_r.write_abort_flag, ctrl_r.write_enable_bit,
    ctrl_r.write_start, 1'b0};
  wire logic [7:0] stat_byte = {6'h00, stall_r, done_r};
  assign rdata_nxt = !REG_REQ.rd ? `FSC_BYTE_ZERO :
    hit(REG_REQ.addr, `FSC_OFF_CTRL) ? ctrl_byte :
    hit(REG_REQ.addr, `FSC_OFF_LATCH) ? latch_r :
    hit(REG_REQ.addr, `FSC_OFF_PTR_L) ? ptr_r[7:0] :
    hit(REG_REQ.addr, `FSC_OFF_PTR_H) ? ptr_r[15:8] :
    hit(REG_REQ.addr, `FSC_OFF_PTR_U) ? {2'h0, ptr_r[21:16]} :
    hit(REG_REQ.addr, `FSC_OFF_STAT) ? stat_byte : `FSC_BYTE_ZERO;

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= fsc_pkg::ST_IDLE;
      ul_r <= fsc_pkg::UL_NONE;
      ctrl_r <= '0;
      cmd_r <= '0;
      cnt_r <= '0;
      ptr_r <= `FSC_PTR_RST;
      latch_r <= `FSC_BYTE_ZERO;
      ben_r <= `FSC_BYTE_ZERO;
      rdata_r <= `FSC_BYTE_ZERO;
    end else begin
      state_r <= state_nxt;
      ul_r <= ul_nxt;
      ctrl_r <= ctrl_nxt;
      cmd_r <= cmd_nxt;
      cnt_r <= cnt_nxt;
      ptr_r <= ptr_nxt;
      latch_r <= latch_nxt;
      ben_r <= ben_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hi1_r <= 1'b0;
      hi2_r <= 1'b0;
      rd_pend_r <= 1'b0;
      stall_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      hi1_r <= ptr_r[0];
      hi2_r <= hi1_r;
      rd_pend_r <= cmd_r.rd_en;
      stall_r <= state_nxt != fsc_pkg::ST_IDLE;
      done_r <= done_nxt;
    end
  end

  assign REG_RDATA = rdata_r;
  assign FLASH_CMD = cmd_r;
  assign FLASH_PROG_DATA = hold_r;
  assign FLASH_BYTE_EN = ben_r;
  assign CORE_STALL = stall_r;
  assign WRITE_DONE_FLAG = done_r;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_unlock;
    (wr_unl && wd == `FSC_KEY1) ##1 (wr_unl && wd == `FSC_KEY2);
  endsequence
  sequence s_go_legal;
    go_req && wd[`FSC_B_WRITE_ENABLE_BIT] && wd[`FSC_B_PGM] && !wd[`FSC_B_CFG];
  endsequence
  sequence s_finish;
    !idle && cnt_r == CNT_LAST && !ABORT_REQ;
  endsequence

  property p_rd_fetch;
    TBL_RD_OP && idle |=> FLASH_CMD.rd_en ##1 1'b1 ##1
      latch_r == ($past(hi2_r) ? $past(FLASH_RDATA[15:8])
        : $past(FLASH_RDATA[7:0]));
  endproperty
  a_rd_fetch: assert property (p_rd_fetch)
    else $error("table read did not load the latch");

  property p_rd_byte_sel;
    TBL_RD_OP && idle |=> hi1_r == $past(ptr_r[0]) ##1 hi2_r == $past(hi1_r);
  endproperty
  a_rd_byte_sel: assert property (p_rd_byte_sel)
    else $error("byte select lost on the read path");

  property p_unlock_start;
    s_unlock ##1 s_go_legal |=> CORE_STALL && FLASH_CMD.pump_en;
  endproperty
  a_unlock_start: assert property (p_unlock_start)
    else $error("unlocked start did not stall the core");

  property p_locked_start;
    s_go_legal and (ul_r != fsc_pkg::UL_ARMED)
      |=> !CORE_STALL && ctrl_r.write_abort_flag;
  endproperty
  a_locked_start: assert property (p_locked_start)
    else $error("start without unlock was not refused");

  property p_erase_row;
    FLASH_CMD.erase |-> FLASH_CMD.addr[4:0] == 5'h00 && !FLASH_CMD.prog;
  endproperty
  a_erase_row: assert property (p_erase_row)
    else $error("erase address not row aligned");

  property p_stall_hold;
    !idle && cnt_r != CNT_LAST && !ABORT_REQ |=> CORE_STALL;
  endproperty
  a_stall_hold: assert property (p_stall_hold)
    else $error("stall released before the timer ended");

  property p_stall_end;
    s_finish |=> !CORE_STALL && !ctrl_r.write_start && WRITE_DONE_FLAG;
  endproperty
  a_stall_end: assert property (p_stall_end)
    else $error("write end did not clear go and release core");

  property p_hold_refill;
    s_finish |=> hold_r == {8{`FSC_HOLD_RST}};
  endproperty
  a_hold_refill: assert property (p_hold_refill)
    else $error("holding bytes not refilled after write");

  property p_table_write;
    TBL_WR_OP && idle |=> hold_r[$past(ptr_r[2:0])] == $past(latch_r)
      && !FLASH_CMD.prog && !FLASH_CMD.erase;
  endproperty
  a_table_write: assert property (p_table_write)
    else $error("table write did not load only its holding byte");

  property p_done_sticky;
    WRITE_DONE_FLAG && !(wr_stat && wd[`FSC_B_DONE]) |=> WRITE_DONE_FLAG;
  endproperty
  a_done_sticky: assert property (p_done_sticky)
    else $error("write done flag dropped without a clear");

  property p_abort;
    !idle && ABORT_REQ |=> !CORE_STALL && ctrl_r.write_abort_flag
      && ctrl_r.program_space_select == $past(ctrl_r.program_space_select);
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort did not end the write with the flag set");

  property p_byte_mask;
    FLASH_CMD.prog |-> FLASH_BYTE_EN[0] == (hold_r[0] != `FSC_HOLD_RST);
  endproperty
  a_byte_mask: assert property (p_byte_mask)
    else $error("unchanged byte not masked during program");

endmodule // self_program_flash_controller

/* File: testbench/flash_array_model.sv */
// Behavioural flash array on the far side of the sequencer.
// Assumes word addresses on the command bus, one-cycle read latency.
module flash_array_model (
  input wire logic clk,
  input wire fsc_pkg::flash_cmd_t cmd,
  input wire logic [63:0] prog_data,
  input wire logic [7:0] byte_en,
  output logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [128];
  logic busy_q;
  logic [6:0] wa;

  initial begin
    rdata = 16'h0000;
    busy_q = 1'b0;
    for (int i = 0; i < 128; i++) begin
      mem[i] = {i[7:0], ~i[7:0]};
    end
  end

  // Idle bus toggles so a late sample never matches by luck
  always @(posedge clk) begin
    rdata <= cmd.rd_en ? mem[cmd.addr[6:0]] : ~rdata;
    busy_q <= cmd.erase | cmd.prog;
    if (cmd.erase && !busy_q) begin
      for (int i = 0; i < 32; i++) begin
        mem[{cmd.addr[6:5], i[4:0]}] = 16'hFFFF;
      end
    end
    // Cells only clear bits, as real flash does
    if (cmd.prog && !busy_q) begin
      for (int i = 0; i < 8; i++) begin
        wa = {cmd.addr[6:2], i[2:1]};
        if (byte_en[i]) begin
          mem[wa][(i%2)*8 +: 8] = mem[wa][(i%2)*8 +: 8] & prog_data[8*i +: 8];
        end
      end
    end
  end
endmodule // flash_array_model

/* File: testbench/tb.sv */
// Self-checking bench: register port, table ops, erase, program, aborts.
// Assumes flash_array_model as the far side, short programming timer.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PC = 20;
  logic clk;
  logic rst_n;
  fsc_pkg::reg_req_t req;
  logic [7:0] rdata;
  logic rd_op, wr_op, abort_req, stall, done;
  logic [15:0] f_rdata;
  fsc_pkg::flash_cmd_t cmd;
  logic [63:0] pdata;
  logic [7:0] ben;
  int err_count, check_count;

  self_program_flash_controller #(.PROG_CYCLES(PC)) uut (
    .CLK(clk), .RST_N(rst_n), .REG_REQ(req), .REG_RDATA(rdata),
    .TBL_RD_OP(rd_op), .TBL_WR_OP(wr_op), .ABORT_REQ(abort_req),
    .FLASH_RDATA(f_rdata), .FLASH_CMD(cmd), .FLASH_PROG_DATA(pdata),
    .FLASH_BYTE_EN(ben), .CORE_STALL(stall), .WRITE_DONE_FLAG(done));
  flash_array_model far (.clk(clk), .cmd(cmd), .prog_data(pdata),
    .byte_en(ben), .rdata(f_rdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rc(input logic [2:0] a, input logic [7:0] e,
                    input string nm);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    chk(nm, e, rdata);
    @(negedge clk);
    chk("read idle", 8'h00, rdata);
  endtask

  task automatic setp(input logic [21:0] p);
    wr(3'h3, p[7:0]);
    wr(3'h4, p[15:8]);
    wr(3'h5, {2'b00, p[21:16]});
  endtask

  task automatic op(input bit w);
    @(posedge clk);
    if (w) wr_op <= 1'b1;
    else rd_op <= 1'b1;
    @(posedge clk);
    wr_op <= 1'b0;
    rd_op <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic tread(input logic [21:0] p, input logic [7:0] e);
    setp(p);
    op(1'b0);
    rc(3'h2, e, "table latch");
  endtask

  task automatic tload(input logic [21:0] p, input logic [7:0] d);
    setp(p);
    wr(3'h2, d);
    op(1'b1);
  endtask

  // Keys and go back to back, so the unlock check sees its sequence
  task automatic start(input logic [7:0] ctl);
    @(posedge clk);
    req <= '{addr: 3'h1, wdata: 8'h55, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '{addr: 3'h1, wdata: 8'hAA, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '{addr: 3'h0, wdata: ctl, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
  endtask

  task automatic long_wr(input logic [7:0] ctl, input logic [20:0] ea,
                         input logic [7:0] een);
    int n;
    int cnt;
    cnt = 0;
    start(ctl);
    for (n = 0; n < 4 * PC; n++) begin
      @(negedge clk);
      if (stall === 1'b1 && cnt == 0) begin
        chk("block addr", ea, cmd.addr);
        chk("pump", 1'b1, cmd.pump_en);
        chk("kind", {ctl[4], ~ctl[4]}, {cmd.erase, cmd.prog});
        if (!ctl[4]) chk("byte en", een, ben);
      end
      if (stall === 1'b1) cnt++;
      else if (cnt > 0) break;
    end
    chk("stall length", PC, cnt);
    if (n == 4 * PC) give_verdict();
    chk("done flag", 1'b1, done);
    chk("holding", {8{8'hFF}}, pdata);
    rc(3'h0, ctl & 8'hCD, "ctrl after");
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 8; i++) rc(3'(i), 8'h00, "reset reg");
    chk("holding", {8{8'hFF}}, pdata);
    chk("stall", 1'b0, stall);
    $display("reset test done");
  endtask

  task automatic t_prog();
    tread(22'h000050, 8'hD7);
    tload(22'h000051, 8'h0F);
    tload(22'h000056, 8'h33);
    chk("holding", 64'hFF33FFFFFFFF0FFF, pdata);
    tread(22'h000051, 8'h28);
    long_wr(8'hA6, 21'h000028, 8'h42);
    rc(3'h6, 8'h01, "status");
    wr(3'h6, 8'h01);
    repeat (2) @(posedge clk);
    chk("done clear", 1'b0, done);
    tread(22'h000051, 8'h08);
    tread(22'h000056, 8'h10);
    tread(22'h000050, 8'hD7);
    $display("program test done");
  endtask

  task automatic t_erase();
    setp(22'h0000AB);
    long_wr(8'h96, 21'h000040, 8'h00);
    wr(3'h6, 8'h01);
    tread(22'h0000AB, 8'hFF);
    tread(22'h000080, 8'hFF);
    tread(22'h00007F, 8'h3F);
    tread(22'h0000C0, 8'h9F);
    $display("erase test done");
  endtask

  task automatic t_bad();
    wr(3'h1, 8'h55);
    wr(3'h1, 8'h11);
    wr(3'h0, 8'hA6);
    repeat (3) @(posedge clk);
    chk("stall", 1'b0, stall);
    rc(3'h0, 8'h8C, "bad key");
    wr(3'h0, 8'h84);
    wr(3'h1, 8'h55);
    wr(3'h1, 8'hAA);
    wr(3'h3, 8'h00);
    wr(3'h0, 8'hA6);
    rc(3'h0, 8'h8C, "late go");
    wr(3'h0, 8'h84);
    start(8'hE6);
    rc(3'h0, 8'hCC, "cfg space");
    wr(3'h0, 8'h84);
    $display("unlock test done");
  endtask

  task automatic t_abort();
    tload(22'h000060, 8'h00);
    start(8'hA6);
    repeat (4) @(posedge clk);
    chk("stall", 1'b1, stall);
    abort_req <= 1'b1;
    @(posedge clk);
    abort_req <= 1'b0;
    repeat (2) @(posedge clk);
    chk("stall", 1'b0, stall);
    chk("done", 1'b0, done);
    chk("holding", 64'hFFFFFFFFFFFFFF00, pdata);
    rc(3'h0, 8'h8C, "abort ctrl");
    $display("abort test done");
  endtask

  initial begin
    rst_n = 1'b0;
    req = '0;
    rd_op = 1'b0;
    wr_op = 1'b0;
    abort_req = 1'b0;
    err_count = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_prog();
    t_erase();
    t_bad();
    t_abort();
    give_verdict();
  end
endmodule // tb
